// >>> inc/sacr_regs.svh
`ifndef SACR_REGS_SVH
`define SACR_REGS_SVH
// Register offsets on the register port.
`define SACR_LEFT_OFS 8'h2a
`define SACR_RIGHT_OFS 8'h2b
// Field positions inside each speaker control byte.
`define SACR_RSVD_HI_MSB 7
`define SACR_RSVD_HI_LSB 5
`define SACR_GAIN_MSB 4
`define SACR_GAIN_LSB 3
`define SACR_UNMUTE_BIT 2
`define SACR_RSVD_LO_BIT 1
`define SACR_DONE_BIT 0
// Reset values of the writable fields.
`define SACR_RST_RSVD_HI 3'h0
`define SACR_RST_GAIN 2'h0
`define SACR_RST_UNMUTE 1'h0
`define SACR_RST_RSVD_LO 1'h0
// Time between two gain steps of an output stage, and the clock period.
`define SACR_GAIN_STEP_NS 1000
`define SACR_CLK_PERIOD_NS 10
// Cycles between two gain steps, rounded down, at least one.
`define SACR_GAIN_STEP_CYC ((`SACR_GAIN_STEP_NS / `SACR_CLK_PERIOD_NS) < 1 ? 1 : \
  (`SACR_GAIN_STEP_NS / `SACR_CLK_PERIOD_NS))
`endif

// >>> inc/sacr_pkg.sv
package sacr_pkg;
  // Output stage gain codes.
  typedef enum logic [1:0] {
    SACR_GAIN_6DB = 2'h0,
    SACR_GAIN_12DB = 2'h1,
    SACR_GAIN_18DB = 2'h2,
    SACR_GAIN_24DB = 2'h3
  } sacr_gain_e;
  // Writable content of one speaker control register.
  typedef struct packed {
    logic [2:0] rsvd_hi;
    sacr_gain_e gain;
    logic unmute;
    logic rsvd_lo;
  } sacr_stage_s;
  // Register port request.
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sacr_req_s;
  // Gain ramp states, one-hot.
  typedef enum logic [1:0] {
    SACR_ST_SETTLED = 2'b01,
    SACR_ST_RAMP = 2'b10
  } sacr_state_e;
endpackage

// >>> hdl/sacr_stage.sv
`timescale 1ns/100ps
`default_nettype none
`include "sacr_regs.svh"
module sacr_stage
  import sacr_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Addressed write and gain step pulse.
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  input wire logic step_en,
  // Stored controls, applied gain and settled flag.
  output var sacr_stage_s ctrl_ff,
  output var sacr_gain_e applied_ff,
  output logic done
);
  sacr_state_e state_ff; // Ramp state.
  sacr_state_e nxt_state; // Next ramp state.
  sacr_stage_s nxt_ctrl; // Next control content.
  sacr_gain_e nxt_applied; // Next applied gain.
  wire logic up; // Applied gain is below the target.

  // Bit zero of the write data is dropped: the settled flag is hardware only.
  assign nxt_ctrl = wr_en ? sacr_stage_s'(wdata[7:1]) : ctrl_ff;
  assign up = applied_ff < ctrl_ff.gain;
  // The applied gain walks one code per step pulse toward the target.
  assign nxt_applied = (step_en && applied_ff != ctrl_ff.gain) ?
    sacr_gain_e'(up ? applied_ff + 2'h1 : applied_ff - 2'h1) : applied_ff;
  // A new target seen in the same cycle as the last step still counts.
  assign nxt_state = (nxt_applied != nxt_ctrl.gain) ? SACR_ST_RAMP : SACR_ST_SETTLED;
  assign done = state_ff == SACR_ST_SETTLED;

  // Control fields, reset to muted at the lowest gain.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= {`SACR_RST_RSVD_HI, `SACR_RST_GAIN, `SACR_RST_UNMUTE, `SACR_RST_RSVD_LO};
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Applied gain and ramp state.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      applied_ff <= SACR_GAIN_6DB;
      state_ff <= SACR_ST_SETTLED;
    end else begin
      applied_ff <= nxt_applied;
      case (state_ff)
        SACR_ST_SETTLED: state_ff <= nxt_state;
        SACR_ST_RAMP: state_ff <= nxt_state;
        default: state_ff <= SACR_ST_SETTLED;
      endcase
    end
  end

  // The applied gain only moves on a step pulse.
  property p_step_only;
    @(posedge clk_sys) disable iff (!arst_n)
    !step_en |=> $stable(applied_ff);
  endproperty
  a_step_only: assert property (p_step_only) else $error("Gain moved without step.");
  // Settled means the applied gain equals the stored gain.
  property p_done_match;
    @(posedge clk_sys) disable iff (!arst_n)
    done |-> applied_ff == ctrl_ff.gain;
  endproperty
  a_done_match: assert property (p_done_match) else $error("Settled with gain mismatch.");
endmodule // sacr_stage
`default_nettype wire

// >>> hdl/sacr_top.sv
// How it works
// - Left bits 4:3 pick 6/12/18/24 dB.
// - Left bit 2 zero mutes; resets zero.
// - Left bit 0 reads one when gains applied.
// - Right bits 4:3 pick 6/12/18/24 dB.
// - Right bit 2 zero mutes; resets zero.
// - Right bit 0 reads one when gains applied.
`timescale 1ns/100ps
`default_nettype none
`include "sacr_regs.svh"
module sacr_top
  import sacr_pkg::*;
#(
  parameter int STEP_CYC = `SACR_GAIN_STEP_CYC // Cycles between two gain steps.
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register port from the serial control engine.
  input wire sacr_req_s req,
  output logic [7:0] rdata_ff,
  output logic rvalid_ff,
  // Controls toward the left speaker stage.
  output var sacr_gain_e left_speaker_stage_gain_ff,
  output logic left_speaker_stage_unmute_ff,
  // Controls toward the right speaker stage.
  output var sacr_gain_e right_speaker_stage_gain_ff,
  output logic right_speaker_stage_unmute_ff
);
  int step_cnt_ff; // Step divider count.
  logic step_en_ff; // One-cycle gain step pulse.
  wire logic hit_left; // Request addresses the left register.
  wire logic hit_right; // Request addresses the right register.
  sacr_stage_s left_ctrl; // Stored left controls.
  sacr_stage_s right_ctrl; // Stored right controls.
  sacr_gain_e left_applied; // Gain now applied on the left.
  sacr_gain_e right_applied; // Gain now applied on the right.
  logic left_done; // Left gains settled.
  logic right_done; // Right gains settled.
  wire logic [7:0] nxt_rdata; // Read data for the next cycle.

  // Packs stored controls and the settled flag into a register byte.
  function automatic logic [7:0] pack_reg(input sacr_stage_s c, input logic d);
    pack_reg = {c, d};
  endfunction

  assign hit_left = req.addr == `SACR_LEFT_OFS;
  assign hit_right = req.addr == `SACR_RIGHT_OFS;
  // Unmapped addresses read as zero.
  assign nxt_rdata = hit_left ? pack_reg(left_ctrl, left_done) :
    hit_right ? pack_reg(right_ctrl, right_done) : 8'h00;

  // Divider that paces the gain ramp of both stages.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      step_cnt_ff <= 0;
      step_en_ff <= 1'b0;
    end else begin
      step_cnt_ff <= (step_cnt_ff >= STEP_CYC - 1) ? 0 : step_cnt_ff + 1;
      step_en_ff <= step_cnt_ff >= STEP_CYC - 1;
    end
  end

  // Left stage controls and gain ramp.
  sacr_stage u_left (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .wr_en(req.wr_en && hit_left),
    .wdata(req.wdata),
    .step_en(step_en_ff),
    .ctrl_ff(left_ctrl),
    .applied_ff(left_applied),
    .done(left_done)
  );

  // Right stage controls and gain ramp.
  sacr_stage u_right (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .wr_en(req.wr_en && hit_right),
    .wdata(req.wdata),
    .step_en(step_en_ff),
    .ctrl_ff(right_ctrl),
    .applied_ff(right_applied),
    .done(right_done)
  );

  // Read answer, one cycle after the request.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= req.rd_en;
      if (req.rd_en) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // Amplifier controls, retimed so every output leaves a flip-flop.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      left_speaker_stage_gain_ff <= SACR_GAIN_6DB;
      left_speaker_stage_unmute_ff <= 1'b0;
      right_speaker_stage_gain_ff <= SACR_GAIN_6DB;
      right_speaker_stage_unmute_ff <= 1'b0;
    end else begin
      left_speaker_stage_gain_ff <= left_applied;
      left_speaker_stage_unmute_ff <= left_ctrl.unmute;
      right_speaker_stage_gain_ff <= right_applied;
      right_speaker_stage_unmute_ff <= right_ctrl.unmute;
    end
  end

  // A write to the left register shows on the unmute pin two cycles later.
  sequence s_left_wr;
    req.wr_en && hit_left;
  endsequence
  property p_left_mute;
    @(posedge clk_sys) disable iff (!arst_n)
    s_left_wr |-> ##2 left_speaker_stage_unmute_ff == $past(req.wdata[2], 2);
  endproperty
  a_left_mute: assert property (p_left_mute) else $error("Left mute wrong.");

  // Same for the right register.
  sequence s_right_wr;
    req.wr_en && hit_right;
  endsequence
  property p_right_mute;
    @(posedge clk_sys) disable iff (!arst_n)
    s_right_wr |-> ##2 right_speaker_stage_unmute_ff == $past(req.wdata[2], 2);
  endproperty
  a_right_mute: assert property (p_right_mute) else $error("Right mute wrong.");

  // A left gain change away from the applied gain clears the settled flag.
  // A step landing in the same cycle may reach the new code at once, so that
  // cycle is left out of the check.
  property p_left_pending;
    @(posedge clk_sys) disable iff (!arst_n)
    (req.wr_en && hit_left && !step_en_ff && req.wdata[4:3] != left_applied) |=> !left_done;
  endproperty
  a_left_pending: assert property (p_left_pending) else $error("Left done early.");

  // Same for the right stage.
  property p_right_pending;
    @(posedge clk_sys) disable iff (!arst_n)
    (req.wr_en && hit_right && !step_en_ff && req.wdata[4:3] != right_applied) |=> !right_done;
  endproperty
  a_right_pending: assert property (p_right_pending) else $error("Right done early.");

  // Helper logic for the gain checks: cycles since each stage was last written.
  // Three steps cover the longest ramp, two more the step landing and the retiming.
  localparam int GAIN_WIN = 3 * STEP_CYC + 2; // Cycles after a write by which the gain stands.
  int left_age_ff; // Cycles since the last left write, held at GAIN_WIN.
  int right_age_ff; // Cycles since the last right write, held at GAIN_WIN.
  int nxt_left_age; // Next left age.
  int nxt_right_age; // Next right age.

  // A write restarts the count; otherwise it climbs until the window is over.
  assign nxt_left_age = (req.wr_en && hit_left) ? 0 :
    (left_age_ff >= GAIN_WIN) ? GAIN_WIN : left_age_ff + 1;
  assign nxt_right_age = (req.wr_en && hit_right) ? 0 :
    (right_age_ff >= GAIN_WIN) ? GAIN_WIN : right_age_ff + 1;

  // Age counters, started full because reset leaves both stages settled.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      left_age_ff <= GAIN_WIN;
      right_age_ff <= GAIN_WIN;
    end else begin
      left_age_ff <= nxt_left_age;
      right_age_ff <= nxt_right_age;
    end
  end

  // Once the window after the last left write is over, the pin shows the written gain.
  property p_left_gain;
    @(posedge clk_sys) disable iff (!arst_n)
    left_age_ff == GAIN_WIN |-> left_speaker_stage_gain_ff == left_ctrl.gain;
  endproperty
  a_left_gain: assert property (p_left_gain) else $error("Left gain not applied.");

  // Same for the right stage.
  property p_right_gain;
    @(posedge clk_sys) disable iff (!arst_n)
    right_age_ff == GAIN_WIN |-> right_speaker_stage_gain_ff == right_ctrl.gain;
  endproperty
  a_right_gain: assert property (p_right_gain) else $error("Right gain not applied.");

  // A left read returns the left status bit written into bit zero of the answer.
  property p_read_status;
    @(posedge clk_sys) disable iff (!arst_n)
    (req.rd_en && hit_left) |=> rvalid_ff && rdata_ff[0] == $past(left_done);
  endproperty
  a_read_status: assert property (p_read_status) else $error("Status read wrong.");

  // Writing bit zero never touches the stored right controls' low field.
  property p_ro_bit;
    @(posedge clk_sys) disable iff (!arst_n)
    s_right_wr |=> right_ctrl == sacr_stage_s'($past(req.wdata[7:1]));
  endproperty
  a_ro_bit: assert property (p_ro_bit) else $error("Write data mis-stored.");

  // A left write never lands bit zero in the stored left controls.
  property p_left_ro;
    @(posedge clk_sys) disable iff (!arst_n)
    s_left_wr |=> left_ctrl == sacr_stage_s'($past(req.wdata[7:1]));
  endproperty
  a_left_ro: assert property (p_left_ro) else $error("Left write data mis-stored.");

  // The read answer pulses only after a read strobe.
  property p_rvalid_pulse;
    @(posedge clk_sys) disable iff (!arst_n)
    !req.rd_en |=> !rvalid_ff;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("Read answer without a read.");

  // Unmapped reads answer zero.
  property p_unmapped;
    @(posedge clk_sys) disable iff (!arst_n)
    (req.rd_en && !hit_left && !hit_right) |=> rdata_ff == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero.");
endmodule // sacr_top
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the speaker control register pair.
module tb;
  import sacr_pkg::*;
  // Short gain step so that a full ramp fits in a few cycles.
  localparam int STEP = 2;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  sacr_req_s req = '0;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  sacr_gain_e lg;
  sacr_gain_e rg;
  logic lu;
  logic ru;
  int errors = 0;
  int tests_run = 0;
  // Expected read answers, oldest first.
  logic [7:0] exp_q[$];
  // Random state and the model of both stages (index 0 left, 1 right).
  logic [31:0] seed = 32'h0000b038;
  logic [1:0] m_gain[2] = '{2'h0, 2'h0};
  logic m_unm[2] = '{1'b0, 1'b0};
  logic [1:0] gs[4] = '{2'h3, 2'h1, 2'h2, 2'h0};
  logic [31:0] r;

  sacr_top #(.STEP_CYC(STEP)) dut (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .req(req),
    .rdata_ff(rdata_ff),
    .rvalid_ff(rvalid_ff),
    .left_speaker_stage_gain_ff(lg),
    .left_speaker_stage_unmute_ff(lu),
    .right_speaker_stage_gain_ff(rg),
    .right_speaker_stage_unmute_ff(ru)
  );

  // The clock toggles every half period of 10 ns.
  always #5 clk_sys = ~clk_sys;

  // Xorshift generator for the random writes.
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Expected register byte; reserved bits are always written as zero.
  function automatic logic [7:0] byte_of(input int i, input logic done);
    return {3'h0, m_gain[i], m_unm[i], 1'b0, done};
  endfunction

  // Compares one read answer.
  task automatic cmp_rd(input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED rdata expected %h seen %h", e, s);
    end
  endtask

  // Compares one amplifier control level.
  task automatic cmp_lvl(input string what, input logic [1:0] e, input logic [1:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask

  // One write strobe, held for exactly one edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '0;
  endtask

  // One read strobe; the expected answer is queued first.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    req <= '0;
  endtask

  // Writes a stage and updates the model; b0 lands on the read-only bit.
  task automatic set(input int i, input logic [1:0] g, input logic u, input logic b0);
    wr(i == 0 ? 8'h2a : 8'h2b, {3'h0, g, u, 1'b0, b0});
    m_gain[i] = g;
    m_unm[i] = u;
  endtask

  // Waits out a full ramp, then checks all levels and both registers.
  task automatic chk_all();
    repeat (8 * STEP + 8) @(posedge clk_sys);
    // Levels are looked at half a cycle after the edge, when they have settled.
    @(negedge clk_sys);
    cmp_lvl("left gain", m_gain[0], lg);
    cmp_lvl("left unmute", {1'b0, m_unm[0]}, {1'b0, lu});
    cmp_lvl("right gain", m_gain[1], rg);
    cmp_lvl("right unmute", {1'b0, m_unm[1]}, {1'b0, ru});
    rd(8'h2a, byte_of(0, 1'b1));
    rd(8'h2b, byte_of(1, 1'b1));
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Every read answer is matched against the oldest queued note.
  always @(negedge clk_sys) begin
    if (rvalid_ff === 1'b1) begin
      if (exp_q.size() > 0) begin
        cmp_rd(exp_q.pop_front(), rdata_ff);
      end else begin
        cmp_rd(8'hxx, rdata_ff);
      end
    end
  end

  // Cuts a hang short well beyond the expected run time.
  initial begin
    #200000;
    errors++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    report_and_stop();
  end

  // Main sequence.
  initial begin
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    // Reset state: muted, 6 dB, everything settled.
    chk_all();
    // Every gain code on each stage, with the read-only bit written as one.
    for (int i = 0; i < 2; i++) begin
      for (int k = 0; k < 4; k++) begin
        r[1:0] = m_gain[i];
        set(i, gs[k], 1'b1, 1'b1);
        if (r[1:0] > gs[k] + 2'h1 || gs[k] > r[1:0] + 2'h1) begin
          rd(i == 0 ? 8'h2a : 8'h2b, byte_of(i, 1'b0));
        end
        chk_all();
      end
    end
    // Muting both stages again.
    set(0, m_gain[0], 1'b0, 1'b0);
    set(1, m_gain[1], 1'b0, 1'b0);
    chk_all();
    // Unmapped places read zero and ignore writes.
    wr(8'h2c, 8'h1c);
    rd(8'h2c, 8'h00);
    rd(8'h29, 8'h00);
    chk_all();
    // Random retargets, several in a row before the ramp can finish.
    repeat (6) begin
      repeat (3) begin
        seed = xs(seed);
        set(int'(seed[0]), seed[4:3], seed[2], seed[1]);
      end
      chk_all();
    end
    // A reset in mid-ramp brings back the muted, lowest-gain, settled state.
    set(0, 2'h3, 1'b1, 1'b0);
    set(1, 2'h2, 1'b1, 1'b0);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    m_gain = '{2'h0, 2'h0};
    m_unm = '{1'b0, 1'b0};
    chk_all();
    repeat (4) @(posedge clk_sys);
    // Every queued read must have been answered.
    cmp_lvl("pending reads", 2'h0, (exp_q.size() == 0) ? 2'h0 : 2'h1);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
